// File: design/errconf_pkg.sv
package errconf_pkg;

  // Counter limits
  localparam int unsigned TEC_W          = 9;
  localparam int unsigned REC_W          = 8;
  localparam logic [8:0]  PASSIVE_LIMIT  = 9'h080;
  localparam logic [8:0]  BUSOFF_LIMIT   = 9'h100;
  localparam logic [7:0]  REC_MAX        = 8'hff;
  localparam logic [7:0]  REC_RELOAD     = 8'h77;
  localparam logic [7:0]  REC_ACTIVE_TOP = 8'h7f;

  // Step sizes
  localparam logic [3:0]  STEP_SMALL     = 4'h1;
  localparam logic [3:0]  STEP_LARGE     = 4'h8;

  // Bit run lengths
  localparam int unsigned SUSPEND_BITS   = 8;
  localparam int unsigned FLAG_DOM_FIRST = 14;
  localparam int unsigned FLAG_DOM_NEXT  = 8;
  localparam int unsigned RECOV_RUN_BITS = 11;
  localparam int unsigned RECOV_RUNS     = 128;

  // Fault confinement states
  typedef enum logic [1:0] {
    ERR_ACTIVE,
    ERR_PASSIVE,
    BUS_OFF
  } conf_state_t;

  // Per-bit events from the protocol engine, one bit-time pulse each
  typedef struct packed {
    logic bit_tick;        // One sampled bit
    logic rx_bit;          // Sampled bus level, 1 = recessive
    logic is_tx;           // Node is transmitter of current frame
    logic err_detect;      // Error detected, flag starts this bit
    logic bit_err_flag;    // Bit error while sending active/overload flag
    logic ack_err_quiet;   // Passive ack error with quiet passive flag
    logic arb_stuff_err;   // Stuff error on recessive stuff bit in arbitration
    logic flag_active;     // Active-error or overload flag being sent
    logic flag_passive;    // Passive-error flag just completed
    logic first_after_flag;// First bit after own error flag
    logic tx_ok;           // Transmission finished without error
    logic rx_ok;           // Reception finished and acknowledged
    logic tx_end;          // Own transmission finished
  } bit_events_t;

endpackage

// File: design/dominant_run.sv
`timescale 1ns/1ns
// Counts dominant bits after a flag start and pulses on each penalty point
module dominant_run #(
  parameter int unsigned FIRST = 14,
  parameter int unsigned NEXT  = 8
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bit stream
  input  wire logic start,
  input  wire logic tick,
  input  wire logic dominant,
  // Penalty pulse
  output logic      hit
);

  initial begin
    if (FIRST < 1 || NEXT < 1 || FIRST > 255 || NEXT > FIRST) begin
      $error("dominant_run: bad run lengths");
    end
  end

  logic [7:0] cnt_q, cnt_d;
  logic       arm_q, arm_d;

  // Armed at flag start; a recessive bit ends the run
  always_comb begin
    cnt_d = cnt_q;
    arm_d = arm_q;
    hit   = 1'b0;
    if (start) begin
      arm_d = 1'b1;
      cnt_d = 8'h00;
    end else if (arm_q && tick) begin
      if (!dominant) begin
        arm_d = 1'b0;
      end else if (cnt_q == 8'(FIRST - 1)) begin
        hit   = 1'b1;
        cnt_d = 8'(FIRST - NEXT); // Every further NEXT bits
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      arm_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      arm_q <= arm_d;
    end
  end

endmodule

// File: design/recessive_runs.sv
`timescale 1ns/1ns
// Counts runs of recessive bits for bus off recovery
module recessive_runs #(
  parameter int unsigned RUN_BITS = 11,
  parameter int unsigned RUNS     = 128
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic enable,
  input  wire logic tick,
  input  wire logic recessive,
  // Result
  output logic      done
);

  initial begin
    if (RUN_BITS < 1 || RUN_BITS > 15 || RUNS < 1 || RUNS > 255) begin
      $error("recessive_runs: bad counts");
    end
  end

  logic [3:0] bits_q, bits_d;
  logic [7:0] runs_q, runs_d;

  // Dominant restarts the bit count; finished runs are kept
  always_comb begin
    bits_d = bits_q;
    runs_d = runs_q;
    done   = 1'b0;
    if (!enable) begin
      bits_d = 4'h0;
      runs_d = 8'h00;
    end else if (tick) begin
      if (!recessive) begin
        bits_d = 4'h0;
      end else if (bits_q == 4'(RUN_BITS - 1)) begin
        bits_d = 4'h0;
        if (runs_q == 8'(RUNS - 1)) begin
          done   = 1'b1;
          runs_d = 8'h00;
        end else begin
          runs_d = runs_q + 8'h01;
        end
      end else begin
        bits_d = bits_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bits_q <= 4'h0;
      runs_q <= 8'h00;
    end else begin
      bits_q <= bits_d;
      runs_q <= runs_d;
    end
  end

endmodule

// File: design/can_error_confinement.sv
`timescale 1ns/1ns
// Behaviour
// - Error active node sends active error flags
// - Error passive node never signals dominantly receiving
// - Error passive node sends passive error flags
// - Passive transmitter waits eight suspend bits after
// - Bus off node neither transmits nor receives
// - State derived from both counters' thresholds
// - Increments apply at first flag bit
// - Receiver error adds one, except flag bit errors
// - Dominant first bit after flag adds eight
// - Transmitter sending error flag adds eight
// - Quiet passive ack error, arbitration stuff: no change
// - Transmitter flag bit error adds eight
// - Receiver flag bit error adds eight
// - Fourteen dominant then every eight adds eight
// - Eight dominant after passive flag adds eight
// - Successful transmit decrements, floor at zero
// - Successful receive decrements or reloads in range
// - 128 runs of 11 recessive clear both
// - Coinciding conditions all applied together
module can_error_confinement #(
  parameter int unsigned SUSPEND_LEN = errconf_pkg::SUSPEND_BITS,
  parameter int unsigned RECOV_BITS  = errconf_pkg::RECOV_RUN_BITS,
  parameter int unsigned RECOV_COUNT = errconf_pkg::RECOV_RUNS
) (
  // Clock and reset
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST_N,
  // Bit events from the protocol engine
  input  wire errconf_pkg::bit_events_t EV,
  // Flag and access control
  output logic                          FLAG_ACTIVE_REQ,
  output logic                          FLAG_PASSIVE_REQ,
  output logic                          TX_ALLOWED,
  output logic                          RX_ALLOWED,
  output logic                          SUSPEND_BUSY,
  // Status
  output logic [8:0]                    TEC,
  output logic [7:0]                    REC,
  output errconf_pkg::conf_state_t      STATE,
  output logic                          STATE_CHANGE
);

  initial begin
    if (SUSPEND_LEN < 1 || SUSPEND_LEN > 15) begin
      $error("can_error_confinement: bad suspend length");
    end
    // The recovery watcher holds a 4-bit bit count and an 8-bit run count
    if (RECOV_BITS < 1 || RECOV_BITS > 15) begin
      $error("can_error_confinement: bad recovery run length");
    end
    if (RECOV_COUNT < 1 || RECOV_COUNT > 255) begin
      $error("can_error_confinement: bad recovery run count");
    end
  end

  errconf_pkg::conf_state_t state_q, state_d;
  logic [8:0]               tec_q, tec_d;
  logic [7:0]               rec_q, rec_d;
  logic [3:0]               susp_q, susp_d;
  logic                     chg_q, chg_d;
  logic                     fa_q, fa_d;
  logic                     fp_q, fp_d;
  logic                     txa_q, txa_d;
  logic                     rxa_q, rxa_d;
  logic                     sb_q, sb_d;
  logic                     act_hit;
  logic                     pas_hit;
  logic                     recov_done;
  logic                     dominant;
  logic                     bus_off;

  assign dominant = !EV.rx_bit;
  assign bus_off  = (state_q == errconf_pkg::BUS_OFF);

  // Run of dominant bits from the start of an active error flag (error detected while error active)
  dominant_run #(
    .FIRST (errconf_pkg::FLAG_DOM_FIRST),
    .NEXT  (errconf_pkg::FLAG_DOM_NEXT)
  ) u_act_run (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .start    (EV.err_detect && state_q == errconf_pkg::ERR_ACTIVE),
    .tick     (EV.bit_tick),
    .dominant (dominant),
    .hit      (act_hit)
  );

  // Run after a passive flag: first penalty after eight, then every eight
  dominant_run #(
    .FIRST (errconf_pkg::FLAG_DOM_NEXT),
    .NEXT  (errconf_pkg::FLAG_DOM_NEXT)
  ) u_pas_run (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .start    (EV.flag_passive),
    .tick     (EV.bit_tick),
    .dominant (dominant),
    .hit      (pas_hit)
  );

  // Recovery watcher runs only while bus off
  recessive_runs #(
    .RUN_BITS (RECOV_BITS),
    .RUNS     (RECOV_COUNT)
  ) u_recov (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .enable    (bus_off),
    .tick      (EV.bit_tick),
    .recessive (EV.rx_bit),
    .done      (recov_done)
  );

  // Saturating helpers keep the counters from wrapping
  function automatic logic [8:0] tec_add(input logic [8:0] v, input logic [3:0] s);
    logic [9:0] sum;
    sum = {1'b0, v} + {6'h00, s};
    tec_add = sum[9] ? 9'h1ff : sum[8:0];
  endfunction

  function automatic logic [7:0] rec_add(input logic [7:0] v, input logic [3:0] s);
    logic [8:0] sum;
    sum = {1'b0, v} + {5'h00, s};
    rec_add = sum[8] ? errconf_pkg::REC_MAX : sum[7:0];
  endfunction

  // Counter update; every matching condition is summed in one pass
  always_comb begin
    tec_d = tec_q;
    rec_d = rec_q;
    if (bus_off) begin
      if (recov_done) begin
        tec_d = 9'h000;
        rec_d = 8'h00;
      end
    end else if (EV.bit_tick) begin
      if (EV.is_tx) begin
        // Flag start is the first flag bit
        if (EV.err_detect && !EV.ack_err_quiet && !EV.arb_stuff_err) begin
          tec_d = tec_add(tec_d, errconf_pkg::STEP_LARGE);
        end
        if (EV.bit_err_flag) begin
          tec_d = tec_add(tec_d, errconf_pkg::STEP_LARGE);
        end
        if (act_hit) begin
          tec_d = tec_add(tec_d, errconf_pkg::STEP_LARGE);
        end
        if (pas_hit) begin
          tec_d = tec_add(tec_d, errconf_pkg::STEP_LARGE);
        end
        if (EV.tx_ok && tec_d != 9'h000) begin
          tec_d = tec_d - 9'h001;
        end
      end else begin
        if (EV.err_detect && !EV.bit_err_flag) begin
          rec_d = rec_add(rec_d, errconf_pkg::STEP_SMALL);
        end
        if (EV.first_after_flag && dominant) begin
          rec_d = rec_add(rec_d, errconf_pkg::STEP_LARGE);
        end
        if (EV.bit_err_flag) begin
          rec_d = rec_add(rec_d, errconf_pkg::STEP_LARGE);
        end
        if (act_hit) begin
          rec_d = rec_add(rec_d, errconf_pkg::STEP_LARGE);
        end
        if (pas_hit) begin
          rec_d = rec_add(rec_d, errconf_pkg::STEP_LARGE);
        end
        if (EV.rx_ok) begin
          if (rec_d > errconf_pkg::REC_ACTIVE_TOP) begin
            rec_d = errconf_pkg::REC_RELOAD;
          end else if (rec_d != 8'h00) begin
            rec_d = rec_d - 8'h01;
          end
        end
      end
    end
  end

  // State follows the counters' next values
  always_comb begin
    if (tec_d >= errconf_pkg::BUSOFF_LIMIT) begin
      state_d = errconf_pkg::BUS_OFF;
    end else if (tec_d >= errconf_pkg::PASSIVE_LIMIT ||
                 {1'b0, rec_d} >= errconf_pkg::PASSIVE_LIMIT) begin
      state_d = errconf_pkg::ERR_PASSIVE;
    end else begin
      state_d = errconf_pkg::ERR_ACTIVE;
    end
    chg_d = (state_d != state_q);
  end

  // Flag type chosen by the state at the moment of detection
  always_comb begin
    fa_d = 1'b0;
    fp_d = 1'b0;
    if (EV.bit_tick && EV.err_detect) begin
      unique case (state_q)
        errconf_pkg::ERR_ACTIVE:  fa_d = 1'b1;
        errconf_pkg::ERR_PASSIVE: fp_d = 1'b1;
        errconf_pkg::BUS_OFF:     fa_d = 1'b0;
      endcase
    end
  end

  // Suspend gap after own transmission while passive
  always_comb begin
    susp_d = susp_q;
    if (EV.bit_tick && EV.tx_end && state_q == errconf_pkg::ERR_PASSIVE) begin
      susp_d = 4'(SUSPEND_LEN);
    end else if (EV.bit_tick && susp_q != 4'h0) begin
      // A dominant bit means another node started; the gap is moot then
      susp_d = dominant ? 4'h0 : susp_q - 4'h1;
    end
  end

  // Access levels built from next state and gap, so they turn on the
  // same edge as STATE and leave the block straight from flip-flops
  always_comb begin
    txa_d = (state_d != errconf_pkg::BUS_OFF) && (susp_d == 4'h0);
    rxa_d = (state_d != errconf_pkg::BUS_OFF);
    sb_d  = (susp_d != 4'h0);
  end

  // Counter registers
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      tec_q <= 9'h000;
      rec_q <= 8'h00;
    end else begin
      tec_q <= tec_d;
      rec_q <= rec_d;
    end
  end

  // State and its one-cycle change event
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_q <= errconf_pkg::ERR_ACTIVE;
      chg_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      chg_q   <= chg_d;
    end
  end

  // Flag requests, one cycle each
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      fa_q <= 1'b0;
      fp_q <= 1'b0;
    end else begin
      fa_q <= fa_d;
      fp_q <= fp_d;
    end
  end

  // Suspend countdown
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      susp_q <= 4'h0;
    end else begin
      susp_q <= susp_d;
    end
  end

  // Access levels; both open after reset, no gap pending
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      txa_q <= 1'b1;
      rxa_q <= 1'b1;
      sb_q  <= 1'b0;
    end else begin
      txa_q <= txa_d;
      rxa_q <= rxa_d;
      sb_q  <= sb_d;
    end
  end

  // Outputs
  assign FLAG_ACTIVE_REQ  = fa_q;
  assign FLAG_PASSIVE_REQ = fp_q;
  assign SUSPEND_BUSY     = sb_q;
  assign TX_ALLOWED       = txa_q;
  assign RX_ALLOWED       = rxa_q;
  assign TEC              = tec_q;
  assign REC              = rec_q;
  assign STATE            = state_q;
  assign STATE_CHANGE     = chg_q;

endmodule

// File: testbench/can_peer.sv
`timescale 1ns/1ns
// Other nodes on the shared bus, wired so that any dominant driver wins
module can_peer (
  // Command from the bench
  input  wire logic dom_req,
  // Bus level seen by the node, 1 = recessive
  output logic      bus_rx
);
  // Bus rests recessive when no peer pulls it dominant
  assign bus_rx = ~dom_req;
endmodule

// File: testbench/errconf_props.sv
`timescale 1ns/1ns
// Counter, flag and state relations seen at the top ports
module errconf_props #(
  parameter int unsigned SUSPEND_LEN = 8,
  parameter int unsigned RECOV_BITS  = 11,
  parameter int unsigned RECOV_COUNT = 128
) (
  // Clock and reset
  input wire logic                     CORE_CLK,
  input wire logic                     RST_N,
  // Events
  input wire errconf_pkg::bit_events_t EV,
  // Watched outputs
  input wire logic                     FLAG_ACTIVE_REQ,
  input wire logic                     FLAG_PASSIVE_REQ,
  input wire logic                     TX_ALLOWED,
  input wire logic                     RX_ALLOWED,
  input wire logic                     SUSPEND_BUSY,
  input wire logic [8:0]               TEC,
  input wire logic [7:0]               REC,
  input wire errconf_pkg::conf_state_t STATE,
  input wire logic                     STATE_CHANGE
);
  localparam errconf_pkg::conf_state_t ACT = errconf_pkg::ERR_ACTIVE;
  localparam errconf_pkg::conf_state_t PAS = errconf_pkg::ERR_PASSIVE;
  localparam errconf_pkg::conf_state_t OFF = errconf_pkg::BUS_OFF;
  logic plain;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // Recessive bit with no flag side effects, so only the named step applies
  assign plain = EV.bit_tick && EV.rx_bit && STATE != OFF && !EV.bit_err_flag
    && !EV.first_after_flag;

  a_active_flag: assert property (EV.bit_tick && EV.err_detect && STATE == ACT
    |=> FLAG_ACTIVE_REQ && !FLAG_PASSIVE_REQ) else $error("active flag missing");
  a_passive_flag: assert property (EV.bit_tick && EV.err_detect && STATE == PAS
    |=> FLAG_PASSIVE_REQ && !FLAG_ACTIVE_REQ) else $error("passive flag missing");
  a_suspend_start: assert property (EV.bit_tick && EV.tx_end && STATE == PAS
    |=> SUSPEND_BUSY && !TX_ALLOWED) else $error("suspend gap missing");
  a_busoff_quiet: assert property (STATE == OFF |-> !TX_ALLOWED && !RX_ALLOWED)
    else $error("bus off node still on bus");
  a_state_map: assert property (STATE == (TEC >= 9'h100 ? OFF :
    (TEC >= 9'h080 || REC >= 8'h80) ? PAS : ACT)) else $error("state off counters");
  a_rx_err_inc: assert property (plain && EV.err_detect && !EV.is_tx && !EV.rx_ok
    && REC != 8'hff |=> REC == $past(REC) + 8'h01) else $error("rec step wrong");
  a_tx_flag_inc: assert property (plain && EV.err_detect && EV.is_tx && !EV.tx_ok
    && !EV.ack_err_quiet && !EV.arb_stuff_err && TEC < 9'h1f0
    |=> TEC == $past(TEC) + 9'h008) else $error("tec step wrong");
  a_tx_exempt: assert property (plain && EV.err_detect && EV.is_tx && !EV.tx_ok
    && (EV.ack_err_quiet || EV.arb_stuff_err) |=> $stable(TEC)) else $error("tec moved");
  a_tx_ok_dec: assert property (plain && EV.tx_ok && !EV.err_detect
    |=> TEC == ($past(TEC) == 9'h000 ? 9'h000 : $past(TEC) - 9'h001))
    else $error("tec decrement wrong");
  a_rx_ok_dec: assert property (plain && EV.rx_ok && !EV.err_detect
    |=> REC == ($past(REC) > 8'h7f ? 8'h77 : ($past(REC) == 8'h00 ? 8'h00 : $past(REC) - 8'h01)))
    else $error("rec decrement wrong");
  a_change_event: assert property ($past(RST_N)
    |-> STATE_CHANGE == (STATE != $past(STATE))) else $error("state event wrong");

  // Main scenarios reached
  c_bus_off: cover property (STATE == OFF);
  c_recovered: cover property (STATE_CHANGE && STATE == ACT && $past(STATE) == OFF);
  c_suspend: cover property ($rose(SUSPEND_BUSY));
endmodule

bind can_error_confinement errconf_props #(
  .SUSPEND_LEN(SUSPEND_LEN), .RECOV_BITS(RECOV_BITS), .RECOV_COUNT(RECOV_COUNT)
) props (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .EV(EV), .FLAG_ACTIVE_REQ(FLAG_ACTIVE_REQ),
  .FLAG_PASSIVE_REQ(FLAG_PASSIVE_REQ), .TX_ALLOWED(TX_ALLOWED), .RX_ALLOWED(RX_ALLOWED),
  .SUSPEND_BUSY(SUSPEND_BUSY), .TEC(TEC), .REC(REC), .STATE(STATE),
  .STATE_CHANGE(STATE_CHANGE)
);

// File: testbench/tb_top.sv
`timescale 1ns/1ns
// Bench for the error confinement block
module tb_top;
  localparam errconf_pkg::conf_state_t ACT = errconf_pkg::ERR_ACTIVE;
  localparam errconf_pkg::conf_state_t PAS = errconf_pkg::ERR_PASSIVE;
  localparam errconf_pkg::conf_state_t OFF = errconf_pkg::BUS_OFF;
  logic                     clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     dom = 1'b0;
  logic                     bus_rx;
  errconf_pkg::bit_events_t ev = '0;
  errconf_pkg::bit_events_t evw;
  logic                     fa, fp, txa, rxa, sus, chg;
  logic [8:0]               tec;
  logic [7:0]               rec;
  errconf_pkg::conf_state_t st;
  int                       n_errors = 0;
  int                       checks = 0;
  int                       cyc = 0;

  // Two recovery runs instead of 128 keep the run short
  can_error_confinement #(.RECOV_COUNT(2)) dut (
    .CORE_CLK(clk), .RST_N(rst_n), .EV(evw), .FLAG_ACTIVE_REQ(fa), .FLAG_PASSIVE_REQ(fp),
    .TX_ALLOWED(txa), .RX_ALLOWED(rxa), .SUSPEND_BUSY(sus), .TEC(tec), .REC(rec),
    .STATE(st), .STATE_CHANGE(chg));
  can_peer peer (.dom_req(dom), .bus_rx(bus_rx));

  always #20 clk = ~clk;

  // Bus level comes from the peers, not from the event word
  always_comb begin
    evw = ev;
    evw.rx_bit = bus_rx;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One bit (code bits: 400 tx, 200 err, 100 flag bit err, 80 quiet ack, 40 arb
  // stuff, 8 first after flag, 4 tx ok, 2 rx ok, 1 tx end), then a quiet cycle
  task automatic one(input logic [12:0] e, input logic d);
    @(posedge clk);
    ev <= errconf_pkg::bit_events_t'(e | 13'h1000);
    dom <= d;
    @(posedge clk);
    ev <= '0;
    dom <= 1'b0;
    #1;
  endtask

  task automatic run(input logic [12:0] e, input logic d, input int n);
    repeat (n) one(e, d);
  endtask

  task automatic t_rx_active;
    chk(tec, 9'h000);
    chk(st, ACT);
    one(13'h0200, 1'b0);
    chk(rec, 8'h01);
    chk(fa, 1'b1);
    one(13'h0300, 1'b0);
    chk(rec, 8'h09);
    one(13'h0008, 1'b1);
    chk(rec, 8'h11);
    one(13'h0002, 1'b0);
    chk(rec, 8'h10);
  endtask

  task automatic t_rx_passive;
    run(13'h0008, 1'b1, 13);
    chk(st, ACT);
    one(13'h0008, 1'b1);
    chk(st, PAS);
    chk(chg, 1'b1);
    one(13'h0200, 1'b0);
    chk(fp, 1'b1);
    chk(fa, 1'b0);
    run(13'h0008, 1'b1, 16);
    chk(rec, 8'hff);
    one(13'h0002, 1'b0);
    chk(rec, 8'h77);
    chk(st, ACT);
  endtask

  task automatic t_tx;
    one(13'h0600, 1'b0);
    chk(tec, 9'h008);
    one(13'h0680, 1'b0);
    one(13'h0640, 1'b0);
    chk(tec, 9'h008);
    one(13'h0500, 1'b0);
    chk(tec, 9'h010);
    one(13'h0404, 1'b0);
    chk(tec, 9'h00f);
    one(13'h0604, 1'b0);
    chk(tec, 9'h016);
    run(13'h0400, 1'b1, 13);
    chk(tec, 9'h016);
    one(13'h0400, 1'b1);
    chk(tec, 9'h01e);
    run(13'h0400, 1'b1, 8);
    chk(tec, 9'h026);
    one(13'h0410, 1'b0);
    run(13'h0400, 1'b1, 7);
    chk(tec, 9'h026);
    one(13'h0400, 1'b1);
    chk(tec, 9'h02e);
  endtask

  task automatic t_passive_busoff;
    run(13'h0600, 1'b0, 12);
    chk(st, PAS);
    one(13'h0401, 1'b0);
    chk(sus, 1'b1);
    run(13'h0000, 1'b0, 7);
    chk(txa, 1'b0);
    one(13'h0000, 1'b0);
    chk(txa, 1'b1);
    run(13'h0600, 1'b0, 16);
    chk(st, OFF);
    chk(rxa, 1'b0);
    one(13'h0200, 1'b0);
    chk(rec, 8'h77);
    run(13'h0000, 1'b0, 5);
    one(13'h0000, 1'b1);
    run(13'h0000, 1'b0, 21);
    chk(st, OFF);
    one(13'h0000, 1'b0);
    chk(tec, 9'h000);
    chk(rec, 8'h00);
    chk(chg, 1'b1);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_rx_active();
    t_rx_passive();
    t_tx();
    t_passive_busoff();
    end_of_test();
  end
endmodule
